// >>> hw/icf_top.sv
`timescale 1ns/1ns
// Behaviour
// - Control bit 15 set selects the alternate vector table, clear the standard one.
// - Control bit 14 is read-only, high while a timed irq-disable is active.
// - External irq 0 triggers on falling edge if polarity bit 0 set, else rising.
// - External irq 1 triggers on falling edge if polarity bit 1 set, else rising.
// - External irq 2 triggers on falling edge if polarity bit 2 set, else rising.
// - Control bits 13..3 and flag bit 15 always read zero.
// - A request flag reads one once its source requested, zero otherwise.
// - Upper byte, 14 down to 8: dma1 adc1 uart_tx uart_rx spi_event spi_error timer3.
// - Lower byte, 7 down to 0: timer2 oc2 ic2 dma0 timer1 oc1 ic1 ext0.
// - Reset clears all implemented bits; select, polarity and flags are writable.
// - Hardware sets each flag on request; software clears it afterwards.
module icf_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [2:0] ext_irq_i,
  input wire icf_pkg::icf_periph_req_t periph_req_i,
  input wire logic timed_irq_disable_i,
  output logic alt_vector_table_sel_o,
  output logic [2:0] ext_edge_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic alt_vector_table_sel_q;
  logic [2:0] ext_irq_edge_polarity_q;
  logic timed_irq_disable_active_q;
  logic [15:0] flags_q;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;

  logic wr_ctrl;
  logic wr_flags;
  logic wr_status;
  logic wr_mask;

  // Writes to unmapped addresses fall through and are dropped
  always_comb begin
    wr_ctrl = 1'b0;
    wr_flags = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (wr_i) begin
      case (addr_i)
        icf_pkg::ADDR_CTRL_TWO: begin
          wr_ctrl = 1'b1;
        end
        icf_pkg::ADDR_FLAGS_ZERO: begin
          wr_flags = 1'b1;
        end
        icf_pkg::ADDR_IRQ_STATUS: begin
          wr_status = 1'b1;
        end
        icf_pkg::ADDR_IRQ_MASK: begin
          wr_mask = 1'b1;
        end
        default: begin
          wr_ctrl = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External input synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] ext_meta_q;
  logic [2:0] ext_sync_q;
  logic [2:0] ext_prev_q;
  logic [2:0] ext_hit;
  logic [1:0] warmup_cnt_q;
  logic edge_armed;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ext_meta_q <= icf_pkg::EXT_SYNC_RESET;
      ext_sync_q <= icf_pkg::EXT_SYNC_RESET;
    end else begin
      ext_meta_q <= ext_irq_i;
      ext_sync_q <= ext_meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ext_prev_q <= icf_pkg::EXT_SYNC_RESET;
    end else begin
      ext_prev_q <= ext_sync_q;
    end
  end

  // A pin that idles high must not look like a rising edge once reset lets go,
  // so edges count only after the chain holds real pin samples
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      warmup_cnt_q <= icf_pkg::WARMUP_RESET;
    end else if (warmup_cnt_q != icf_pkg::SYNC_WARMUP_CYCLES) begin
      warmup_cnt_q <= warmup_cnt_q + 2'h1;
    end
  end

  assign edge_armed = (warmup_cnt_q == icf_pkg::SYNC_WARMUP_CYCLES);

  // A polarity change alone fakes no edge; a hit needs ext_prev_q and ext_sync_q to differ
  always_comb begin
    ext_hit = 3'h0;
    for (int i = 0; i < icf_pkg::NUM_EXT; i++) begin
      if (!edge_armed) begin
        ext_hit[i] = 1'b0;
      end else if (ext_irq_edge_polarity_q[i]) begin
        ext_hit[i] = ext_prev_q[i] && !ext_sync_q[i];
      end else begin
        ext_hit[i] = !ext_prev_q[i] && ext_sync_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ext_edge_o <= 3'h0;
    end else begin
      ext_edge_o <= ext_hit;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      alt_vector_table_sel_q <= icf_pkg::CTRL_RESET[icf_pkg::CTRL_ALT_VT_POS];
    end else if (wr_ctrl) begin
      alt_vector_table_sel_q <= wdata_i[icf_pkg::CTRL_ALT_VT_POS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ext_irq_edge_polarity_q <= icf_pkg::CTRL_RESET[icf_pkg::CTRL_EP0_POS +: 3];
    end else if (wr_ctrl) begin
      ext_irq_edge_polarity_q <= wdata_i[icf_pkg::CTRL_EP0_POS +: 3];
    end
  end

  // Status input comes from the core on the same clock: no synchroniser
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      timed_irq_disable_active_q <= 1'b0;
    end else begin
      timed_irq_disable_active_q <= timed_irq_disable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      alt_vector_table_sel_o <= 1'b0;
    end else begin
      alt_vector_table_sel_o <= alt_vector_table_sel_q;
    end
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  logic [15:0] flag_set;

  always_comb begin
    flag_set = 16'h0000;
    flag_set[icf_pkg::FLG_EXT0] = ext_hit[0];
    flag_set[icf_pkg::FLG_IC1] = periph_req_i.in_capture1;
    flag_set[icf_pkg::FLG_OC1] = periph_req_i.out_compare1;
    flag_set[icf_pkg::FLG_T1] = periph_req_i.timer1;
    flag_set[icf_pkg::FLG_DMA0] = periph_req_i.dma_ch0_done;
    flag_set[icf_pkg::FLG_IC2] = periph_req_i.in_capture2;
    flag_set[icf_pkg::FLG_OC2] = periph_req_i.out_compare2;
    flag_set[icf_pkg::FLG_T2] = periph_req_i.timer2;
    flag_set[icf_pkg::FLG_T3] = periph_req_i.timer3;
    flag_set[icf_pkg::FLG_SPI1_ERR] = periph_req_i.spi1_error;
    flag_set[icf_pkg::FLG_SPI1_EVT] = periph_req_i.spi1_event;
    flag_set[icf_pkg::FLG_U1_RX] = periph_req_i.uart1_rx;
    flag_set[icf_pkg::FLG_U1_TX] = periph_req_i.uart1_tx;
    flag_set[icf_pkg::FLG_ADC1] = periph_req_i.adc1_done;
    flag_set[icf_pkg::FLG_DMA1] = periph_req_i.dma_ch1_done;
  end

  logic [15:0] flags_d;

  // Software write replaces the flags, but a request in the same cycle still wins
  always_comb begin
    if (wr_flags) begin
      flags_d = wdata_i | flag_set;
    end else begin
      flags_d = flags_q | flag_set;
    end
    flags_d = flags_d & icf_pkg::FLAGS_IMPL_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flags_q <= icf_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Block interrupt: sticky status, write-one-to-clear, mask
  // ----------------------------------------------------------------
  logic [3:0] ist_set;

  assign ist_set = {|flag_set[icf_pkg::FLG_DMA1:icf_pkg::FLG_IC1], ext_hit};

  logic [3:0] irq_status_d;

  // Set wins over a clearing write in the same cycle, so no event is lost
  always_comb begin
    if (wr_status) begin
      irq_status_d = (irq_status_q & ~wdata_i[3:0]) | ist_set;
    end else begin
      irq_status_d = irq_status_q | ist_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_status_q <= icf_pkg::IST_RESET;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_mask_q <= icf_pkg::IST_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= wdata_i[3:0];
    end
  end

  logic irq_pending;

  assign irq_pending = |(irq_status_q & irq_mask_q);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_pending;
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  logic [15:0] ctrl_word;

  // Unimplemented control bits stay zero because only named fields are placed
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[icf_pkg::CTRL_ALT_VT_POS] = alt_vector_table_sel_q;
    ctrl_word[icf_pkg::CTRL_TIMED_DIS_POS] = timed_irq_disable_active_q;
    ctrl_word[icf_pkg::CTRL_EP0_POS +: 3] = ext_irq_edge_polarity_q;
  end

  always_comb begin
    rd_mux = 16'h0000;
    case (addr_i)
      icf_pkg::ADDR_CTRL_TWO: begin
        rd_mux = ctrl_word;
      end
      icf_pkg::ADDR_FLAGS_ZERO: begin
        rd_mux = flags_q & icf_pkg::FLAGS_IMPL_MASK;
      end
      icf_pkg::ADDR_IRQ_STATUS: begin
        rd_mux[3:0] = irq_status_q;
      end
      icf_pkg::ADDR_IRQ_MASK: begin
        rd_mux[3:0] = irq_mask_q;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // Data holds only in the cycle after the read; zero otherwise
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule

// >>> pkg/icf_pkg.sv
package icf_pkg;

  // ----------------------------------------------------------------
  // Register map (plain port, word addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h0;
  localparam logic [3:0] ADDR_FLAGS_ZERO = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ALT_VT_POS = 15;
  localparam int CTRL_TIMED_DIS_POS = 14;
  localparam int CTRL_EP0_POS = 0;
  localparam int NUM_EXT = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] EXT_SYNC_RESET = 3'h0;
  // Cycles after reset until the edge compare sees real pin samples
  localparam logic [1:0] SYNC_WARMUP_CYCLES = 2'h3;
  localparam logic [1:0] WARMUP_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Flag register fields
  // ----------------------------------------------------------------
  localparam int FLG_EXT0 = 0;
  localparam int FLG_IC1 = 1;
  localparam int FLG_OC1 = 2;
  localparam int FLG_T1 = 3;
  localparam int FLG_DMA0 = 4;
  localparam int FLG_IC2 = 5;
  localparam int FLG_OC2 = 6;
  localparam int FLG_T2 = 7;
  localparam int FLG_T3 = 8;
  localparam int FLG_SPI1_ERR = 9;
  localparam int FLG_SPI1_EVT = 10;
  localparam int FLG_U1_RX = 11;
  localparam int FLG_U1_TX = 12;
  localparam int FLG_ADC1 = 13;
  localparam int FLG_DMA1 = 14;
  localparam logic [15:0] FLAGS_IMPL_MASK = 16'h7fff;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Interrupt status bits of the block itself
  // ----------------------------------------------------------------
  localparam int IST_EXT0_POS = 0;
  localparam int IST_EXT1_POS = 1;
  localparam int IST_EXT2_POS = 2;
  localparam int IST_PERIPH_POS = 3;
  localparam logic [3:0] IST_RESET = 4'h0;

  // Peripheral request strobes, one cycle each, same clock domain
  typedef struct packed {
    logic dma_ch1_done;
    logic adc1_done;
    logic uart1_tx;
    logic uart1_rx;
    logic spi1_event;
    logic spi1_error;
    logic timer3;
    logic timer2;
    logic out_compare2;
    logic in_capture2;
    logic dma_ch0_done;
    logic timer1;
    logic out_compare1;
    logic in_capture1;
  } icf_periph_req_t;

endpackage

// >>> testbench/icf_checker.sv
`timescale 1ns/1ns
module icf_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [2:0] ext_irq_i,
  input wire icf_pkg::icf_periph_req_t periph_req_i,
  input wire logic timed_irq_disable_i,
  input wire logic alt_vector_table_sel_o,
  input wire logic [2:0] ext_edge_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_ALT_VT: assert property (
    wr_i && addr_i == 4'h0 |-> ##2 alt_vector_table_sel_o == $past(wdata_i[15], 2))
    else $error("alt table select wrong");
  AST_TIMED_DISABLE: assert property (
    rd_i && addr_i == 4'h0 && $past(reset_n_i) && timed_irq_disable_i == $past(timed_irq_disable_i)
    |=> rdata_o[14] == $past(timed_irq_disable_i)) else $error("disable status wrong");
  AST_CTRL_UNUSED: assert property (
    rd_i && addr_i == 4'h0 |=> rdata_o[13:3] == 11'h000) else $error("ctrl unused bits set");
  AST_FLAG_UNUSED: assert property (
    rd_i && addr_i == 4'h1 |=> !rdata_o[15]) else $error("flag bit 15 set");
  AST_FLAG_SET: assert property (
    rd_i && addr_i == 4'h1 |=> (rdata_o[14:1] & $past(periph_req_i, 2)) == $past(periph_req_i, 2))
    else $error("request flag not set");
  AST_RDATA_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data outside read");
  AST_IRQ_MASKED: assert property (
    wr_i && addr_i == 4'h3 && wdata_i[3:0] == 4'h0 |-> ##2 !irq_o) else $error("masked irq high");
  AST_EDGE_PULSE: assert property (
    |ext_edge_o |=> (ext_edge_o & $past(ext_edge_o)) == 3'h0) else $error("edge pulse too long");
endmodule
bind icf_top icf_checker i_icf_checker (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .ext_irq_i, .periph_req_i, .timed_irq_disable_i, .alt_vector_table_sel_o,
  .ext_edge_o, .irq_o);

// >>> testbench/icf_periph_model.sv
`timescale 1ns/1ns
module icf_periph_model (
  input wire logic clk_i,
  input wire logic [13:0] req_i,
  output icf_pkg::icf_periph_req_t periph_req_o
);
  // Registered so every strobe leaves on a clock edge, as a real peripheral's would
  always_ff @(posedge clk_i) begin
    periph_req_o <= req_i;
  end
endmodule

// >>> testbench/icf_top_bench.sv
`timescale 1ns/1ns
module icf_top_bench;
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic timed_irq_disable_i = 1'b0, alt_vector_table_sel_o, irq_o;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, v, r;
  logic [2:0] ext_irq_i = 3'h0, ext_edge_o;
  logic [13:0] req = 14'h0000;
  icf_pkg::icf_periph_req_t periph_req_i;
  int n_mismatch = 0, tests_run = 0, seed = 32'h825f6ceb, n_edge = 0;
  logic [2:0] last_edge = 3'h0;
  always #10 clk_i = ~clk_i;
  // Edge pulses last one cycle, so they are caught here rather than polled
  always @(posedge clk_i) begin
    if (|ext_edge_o) begin
      n_edge <= n_edge + 1;
      last_edge <= ext_edge_o;
    end
  end
  icf_top i_icf_top (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ext_irq_i,
    .periph_req_i, .timed_irq_disable_i, .alt_vector_table_sel_o, .ext_edge_o, .irq_o);
  icf_periph_model i_icf_periph_model (.clk_i, .req_i(req), .periph_req_o(periph_req_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic pulse(input logic [13:0] p);
    @(posedge clk_i);
    req <= p;
    @(posedge clk_i);
    req <= 14'h0000;
    cyc(3);
  endtask
  // Struct bit k lands in flag k+1, ext irq 0 owns bit 0
  function automatic logic [15:0] flg(input logic [13:0] p);
    return {1'b0, p, 1'b0};
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    cyc(60000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 10; a++) rdc(a[3:0], 16'h0000);
    wr(4'h0, 16'hffff);
    cyc(2);
    chk(alt_vector_table_sel_o, 1'b1);
    rdc(4'h0, 16'h8007);
    wr(4'h0, 16'h0000);
    cyc(2);
    chk(alt_vector_table_sel_o, 1'b0);
    timed_irq_disable_i <= 1'b1;
    cyc(2);
    wr(4'h0, 16'h0000);
    rdc(4'h0, 16'h4000);
    timed_irq_disable_i <= 1'b0;
    wr(4'h0, 16'h4000);
    cyc(2);
    rdc(4'h0, 16'h0000);
    for (int k = 0; k < 14; k++) begin
      pulse(14'h0001 << k);
      rdc(4'h1, flg(14'h0001 << k));
      wr(4'h1, 16'h0000);
      rdc(4'h1, 16'h0000);
    end
    repeat (20) begin
      r = $random(seed);
      pulse(r[13:0]);
      rdc(4'h1, flg(r[13:0]));
      v = $random(seed);
      wr(4'h1, v);
      rdc(4'h1, v & 16'h7fff);
      wr(4'h1, 16'h0000);
    end
    for (int n = 0; n < 3; n++) begin
      for (int p = 0; p < 2; p++) begin
        wr(4'h0, p[0] ? 16'h0007 : 16'h0000);
        ext_irq_i <= {3{p[0]}};
        cyc(10);
        wr(4'h2, 16'h000f);
        wr(4'h1, 16'h0000);
        ext_irq_i <= {3{p[0]}} ^ (3'h1 << n);
        cyc(10);
        rdc(4'h2, 16'h0001 << n);
        rdc(4'h1, {15'h0000, n == 0});
        chk(last_edge, 3'h1 << n);
        chk(n_edge, 2 * n + p + 1);
        wr(4'h2, 16'h000f);
        ext_irq_i <= {3{p[0]}};
        cyc(10);
        rdc(4'h2, 16'h0000);
      end
    end
    wr(4'h2, 16'h000f);
    wr(4'h3, 16'h0008);
    pulse(14'h0001);
    chk(irq_o, 1'b1);
    wr(4'h3, 16'h0000);
    cyc(2);
    chk(irq_o, 1'b0);
    wr(4'h3, 16'h0008);
    cyc(2);
    chk(irq_o, 1'b1);
    wr(4'h2, 16'h0008);
    cyc(2);
    chk(irq_o, 1'b0);
    tally_and_finish();
  end
endmodule
